// ---- core/lnhc_top.sv ----
// Controller that drives a single-wire bus transceiver through its logic pins:
// mode request, transmit data (two-way, also carries the wake source) and
// receive data. Assumes an external pull-up on the transmit pin and on the
// receive pin, and one 25 MHz clock.
`timescale 1ns/100ps

// Notes on behaviour
// R1 - Transceiver leaves sleep to fail-safe on wake
// R2 - Raise mode request to confirm normal mode
// R3 - Transceiver debounces wake, bus and mode inputs
// R4 - Sleep: inhibit off, transmit and termination off
// R5 - Sleep accepted whatever bus or wake level
// R6 - Power-up and wake give fail-safe, inhibit on; controller and model start in sleep after power-up
// R7 - Per-mode transceiver, inhibit, receive and bus states
// R8 - Bus, mode request, wake, undervoltage end sleep
// R9 - Long dominant pulse forms remote wake request
// R10 - Remote wake holds receive output low
// R11 - Pre-wake receiver on only for monitor time
// R12 - Stuck dominant returns to sleep, edge wakes
// R13 - Bus must recover before new bus wake
// R14 - Filtered low on wake pin forms local wake
// R15 - Local wake: receive low, strong transmit pull-down
// R16 - Sleep reachable even with wake held low
// R17 - New local wake needs wake high over 6us
// R18 - Transmit pin pull strength tells wake source
// R19 - Mode request high clears both wake flags
// R20 - Overtemperature switches bus output off
// R21 - Short removed after sleep gives remote wake
// R22 - Open mode request means sleep
// R23 - Transmit high over 10us before driving bus
// R24 - Transmit low dominant, receive mirrors bus
// R25 - Transmit high before mode request falls
// R26 - Dominant over 40ms forced recessive until recovery
// R27 - Filter and monitor times are cycle counters
module lnhc_top
   import lnhc_pkg::*;
#(
   parameter int DOM_LIMIT_CYC = DOM_TIMEOUT_CYC
) (
   input wire logic i_mclk,
   input wire logic i_rstn,
   // User side
   input wire logic i_go_normal,
   input wire logic i_go_sleep,
   input wire logic i_tx_valid,
   input wire logic i_tx_bit,
   output logic o_tx_ready,
   output logic o_bus_level,
   output logic [1:0] o_mode,
   output logic o_wake_pulse,
   output logic o_wake_local,
   output logic o_regulator_on,
   // Transceiver pins
   output logic o_mode_request,
   output logic o_txd_out,
   output logic o_txd_oe,
   input wire logic i_txd_in,
   input wire logic i_rxd,
   input wire logic i_regulator_inhibit
);

   // ------------------------------------------------------------
   // Pin synchronisers and filters
   // ------------------------------------------------------------
   logic [2:0] rxd_sync_q;
   logic [2:0] txd_sync_q;
   logic [2:0] inh_sync_q;
   logic rxd_f_q;
   logic txd_f_q;
   logic inh_f_q;

   // Three stages each; only the last two feed the filter
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         rxd_sync_q <= SYNC_RST_HI;
         txd_sync_q <= SYNC_RST_HI;
         inh_sync_q <= SYNC_RST_LO;
      end else begin
         rxd_sync_q <= {rxd_sync_q[1:0], i_rxd};
         txd_sync_q <= {txd_sync_q[1:0], i_txd_in};
         inh_sync_q <= {inh_sync_q[1:0], i_regulator_inhibit};
      end
   end

   // Filtered levels
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         rxd_f_q <= 1'b1;
         txd_f_q <= 1'b1;
         inh_f_q <= 1'b0;
      end else begin
         rxd_f_q <= pin_filt(rxd_sync_q[1], rxd_sync_q[2], rxd_f_q);
         txd_f_q <= pin_filt(txd_sync_q[1], txd_sync_q[2], txd_f_q);
         inh_f_q <= pin_filt(inh_sync_q[1], inh_sync_q[2], inh_f_q);
      end
   end

   // ------------------------------------------------------------
   // Mode sequencer
   // ------------------------------------------------------------
   lnhc_state_t state_q;
   lnhc_state_t state_d;
   logic [CNT_W-1:0] tmr_q;
   logic tmr_done;
   logic wake_seen;

   // Wake shows as a low receive line while the transceiver is not in normal mode
   assign wake_seen = !rxd_f_q; // see R10 see R15
   assign tmr_done = (tmr_q == '0);

   // Next state
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_SLEEP: begin
            if (wake_seen) begin
               state_d = ST_WAKE_READ;
            end
         end
         ST_WAKE_READ: begin
            if (tmr_done) begin
               state_d = ST_FAILSAFE;
            end
         end
         ST_FAILSAFE: begin
            if (i_go_normal) begin
               state_d = ST_ARM; // see R2
            end else if (i_go_sleep) begin
               state_d = ST_SLEEP_REQ;
            end
         end
         ST_ARM: begin
            if (i_go_sleep) begin
               state_d = ST_SLEEP_REQ;
            end else if (tmr_done) begin
               state_d = ST_NORMAL; // see R23
            end
         end
         ST_NORMAL: begin
            if (i_go_sleep) begin
               state_d = ST_SLEEP_REQ;
            end
         end
         ST_SLEEP_REQ: begin
            if (tmr_done) begin
               state_d = ST_SLEEP; // see R25
            end
         end
         default: begin
            state_d = ST_SLEEP;
         end
      endcase
   end

   // State register
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_q <= ST_SLEEP;
      end else begin
         state_q <= state_d;
      end
   end

   // Shared timer, loaded on entry to each timed state
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         tmr_q <= '0;
      end else if (state_d != state_q) begin
         case (state_d)
            ST_WAKE_READ: tmr_q <= SETTLE_CYC - 1'b1;
            ST_ARM: tmr_q <= ARM_CYC - 1'b1; // see R23
            ST_SLEEP_REQ: tmr_q <= SLEEP_SETUP_CYC - 1'b1; // see R25
            default: tmr_q <= '0;
         endcase
      end else if (!tmr_done) begin
         tmr_q <= tmr_q - 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Wake source capture and reporting
   // ------------------------------------------------------------
   // Transmit pin is released while reading; pull-up high means remote
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_wake_local <= 1'b0;
         o_wake_pulse <= 1'b0;
      end else begin
         o_wake_pulse <= 1'b0;
         if (state_q == ST_WAKE_READ && tmr_done) begin
            o_wake_local <= !txd_f_q; // see R18
            o_wake_pulse <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Transmit path: buffer, bit timer, dominant guard
   // ------------------------------------------------------------
   logic buf_valid;
   logic buf_bit;
   logic take_bit;
   logic [CNT_W-1:0] bit_tmr_q;
   logic bit_q;
   logic [DOM_W-1:0] dom_cnt_q;
   logic guard_q;
   logic [CNT_W-1:0] guard_tmr_q;
   logic drive_bit;

   lnhc_buf2 #(
      .WIDTH(1)
   ) u_tx_buf (
      .i_mclk(i_mclk),
      .i_rstn(i_rstn),
      .i_in_valid(i_tx_valid),
      .i_in_data(i_tx_bit),
      .o_in_ready(o_tx_ready),
      .o_out_valid(buf_valid),
      .o_out_data(buf_bit),
      .i_out_ready(take_bit)
   );

   // A new bit is taken only in normal mode once the previous one ran out
   assign take_bit = (state_q == ST_NORMAL) && (bit_tmr_q == '0) && buf_valid;

   // Bit timer and current bit; idle is recessive
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         bit_tmr_q <= '0;
         bit_q <= 1'b1;
      end else if (state_q != ST_NORMAL) begin
         bit_tmr_q <= '0;
         bit_q <= 1'b1;
      end else if (take_bit) begin
         bit_tmr_q <= BIT_CYC - 1'b1;
         bit_q <= buf_bit; // see R24
      end else if (bit_tmr_q != '0) begin
         bit_tmr_q <= bit_tmr_q - 1'b1;
      end else begin
         bit_q <= 1'b1;
      end
   end

   // Force recessive after DOM_LIMIT_CYC dominant cycles (the device timeout by default), then hold high for recovery
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         dom_cnt_q <= '0;
         guard_q <= 1'b0;
         guard_tmr_q <= '0;
      end else if (guard_q) begin
         dom_cnt_q <= '0;
         if (guard_tmr_q == '0) begin
            guard_q <= 1'b0;
         end else begin
            guard_tmr_q <= guard_tmr_q - 1'b1;
         end
      end else if (state_q == ST_NORMAL && !bit_q) begin
         if (dom_cnt_q == DOM_W'(DOM_LIMIT_CYC - 1)) begin
            guard_q <= 1'b1; // see R26
            guard_tmr_q <= ARM_CYC - 1'b1;
         end else begin
            dom_cnt_q <= dom_cnt_q + 1'b1;
         end
      end else begin
         dom_cnt_q <= '0;
      end
   end

   assign drive_bit = bit_q || guard_q;

   // ------------------------------------------------------------
   // Pin drivers
   // ------------------------------------------------------------
   // Mode request high from the confirm onward; held through a sleep request so transmit is high before it falls
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_mode_request <= 1'b0;
      end else begin
         o_mode_request <= (state_d == ST_ARM) || (state_d == ST_NORMAL) ||
            ((state_d == ST_SLEEP_REQ) && o_mode_request); // see R2 see R25
      end
   end

   // Transmit pin: released in sleep, while reading the wake source and in fail-safe
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_txd_oe <= 1'b0;
         o_txd_out <= 1'b1;
      end else begin
         case (state_d)
            ST_ARM, ST_SLEEP_REQ: begin
               o_txd_oe <= 1'b1;
               o_txd_out <= 1'b1; // see R23 see R25
            end
            ST_NORMAL: begin
               o_txd_oe <= 1'b1;
               o_txd_out <= (state_q == ST_NORMAL) ? drive_bit : 1'b1; // see R24
            end
            default: begin
               o_txd_oe <= 1'b0; // see R18
               o_txd_out <= 1'b1;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Status to the user
   // ------------------------------------------------------------
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_mode <= MODE_SLEEP;
         o_bus_level <= 1'b1;
         o_regulator_on <= 1'b0;
      end else begin
         case (state_q)
            ST_NORMAL: o_mode <= MODE_NORMAL;
            ST_FAILSAFE, ST_ARM: o_mode <= MODE_FAILSAFE;
            default: o_mode <= MODE_SLEEP;
         endcase
         o_bus_level <= rxd_f_q; // see R24
         o_regulator_on <= inh_f_q;
      end
   end

endmodule

// ---- core/lnhc_pkg.sv ----
// Constants and types shared by the bus transceiver mode controller.
// Assumes a single 25 MHz clock; all times are turned into cycle counts here.
package lnhc_pkg;

   // ------------------------------------------------------------
   // Clock and conversion helpers
   // ------------------------------------------------------------
   localparam int CLK_MHZ = 25;

   // Least time in ns to whole cycles, rounded up, never below one
   function automatic int ns_cyc_min(input int ns);
      int c;
      c = (ns * CLK_MHZ + 999) / 1000;
      return (c < 1) ? 1 : c;
   endfunction

   // Pin filter: a change counts once the second and third stages agree
   function automatic logic pin_filt(input logic s2, input logic s3, input logic old);
      return (s2 == s3) ? s3 : old;
   endfunction

   // ------------------------------------------------------------
   // Times as printed or chosen, and their cycle counts
   // ------------------------------------------------------------
   localparam int TXD_ARM_NS = 10000;      // Transmit high time before driving
   localparam int SETTLE_NS = 4000;        // Pull-up settle before source read
   localparam int SLEEP_SETUP_NS = 1000;   // Transmit high before mode drop
   localparam int BIT_NS = 50000;          // One bit time at 20 kbit/s
   localparam int DOM_TIMEOUT_MS = 40;     // Longest dominant the device allows

   localparam int CNT_W = 11;
   // Strictly longer than the printed time, hence one extra cycle
   localparam logic [CNT_W-1:0] ARM_CYC = CNT_W'(ns_cyc_min(TXD_ARM_NS) + 1);
   localparam logic [CNT_W-1:0] SETTLE_CYC = CNT_W'(ns_cyc_min(SETTLE_NS));
   localparam logic [CNT_W-1:0] SLEEP_SETUP_CYC = CNT_W'(ns_cyc_min(SLEEP_SETUP_NS));
   localparam logic [CNT_W-1:0] BIT_CYC = CNT_W'(ns_cyc_min(BIT_NS));
   localparam int DOM_TIMEOUT_CYC = DOM_TIMEOUT_MS * CLK_MHZ * 1000;
   localparam int DOM_W = 20;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [2:0] SYNC_RST_HI = 3'h7;  // Idle-high pins
   localparam logic [2:0] SYNC_RST_LO = 3'h0;  // Idle-low pins

   // ------------------------------------------------------------
   // Controller states and reported modes
   // ------------------------------------------------------------
   typedef enum logic [5:0] {
      ST_SLEEP     = 6'h01,
      ST_WAKE_READ = 6'h02,
      ST_FAILSAFE  = 6'h04,
      ST_ARM       = 6'h08,
      ST_NORMAL    = 6'h10,
      ST_SLEEP_REQ = 6'h20
   } lnhc_state_t;

   localparam logic [1:0] MODE_SLEEP = 2'h0;
   localparam logic [1:0] MODE_FAILSAFE = 2'h1;
   localparam logic [1:0] MODE_NORMAL = 2'h2;

endpackage

// ---- core/lnhc_buf2.sv ----
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock; the drain side may stall for any time.
`timescale 1ns/100ps

module lnhc_buf2 #(
   parameter int WIDTH = 1
) (
   input wire logic i_mclk,
   input wire logic i_rstn,
   input wire logic i_in_valid,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_in_ready,
   output logic o_out_valid,
   output logic [WIDTH-1:0] o_out_data,
   input wire logic i_out_ready
);

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   logic [WIDTH-1:0] mem_q [2];
   logic wr_ptr_q;
   logic rd_ptr_q;
   logic [1:0] cnt_q;
   logic push;
   logic pop;

   // Handshakes: honest full and empty
   assign o_in_ready = (cnt_q != 2'h2);
   assign o_out_valid = (cnt_q != 2'h0);
   assign push = i_in_valid && o_in_ready;
   assign pop = o_out_valid && i_out_ready;
   assign o_out_data = mem_q[rd_ptr_q];

   // Write side
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         mem_q[0] <= '0;
         mem_q[1] <= '0;
         wr_ptr_q <= 1'b0;
      end else if (push) begin
         mem_q[wr_ptr_q] <= i_in_data;
         wr_ptr_q <= ~wr_ptr_q;
      end
   end

   // Read side
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         rd_ptr_q <= 1'b0;
      end else if (pop) begin
         rd_ptr_q <= ~rd_ptr_q;
      end
   end

   // Fill level
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         cnt_q <= 2'h0;
      end else if (push && !pop) begin
         cnt_q <= cnt_q + 2'h1;
      end else if (pop && !push) begin
         cnt_q <= cnt_q - 2'h1;
      end
   end

endmodule

// ---- bench/lnhc_xcvr_model.sv ----
// Behavioural transceiver at the far side of the mode controller.
// Assumes the bench pulses the wake inputs and pull-ups sit on both logic pins.
`timescale 1ns/100ps
module lnhc_xcvr_model
   import lnhc_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_en,
   input wire logic i_txd_drv,
   input wire logic i_txd_oe,
   input wire logic i_wake_bus,
   input wire logic i_wake_pin,
   output logic o_txd_pin,
   output logic o_rxd,
   output logic o_inh
);
   // -------------------------------------------
   // Pins and mode
   // -------------------------------------------
   logic [1:0] mode_q = MODE_SLEEP;
   logic flag_q = 1'b0;
   logic local_q = 1'b0;
   logic en_q = 1'b0;
   int hi_q = 0;
   int rel_q = 151; // Wake pin taken as released since power-up
   logic bus;
   // Pull-up wins unless driven or strong pull-down marks a local wake
   assign o_txd_pin = i_txd_oe ? i_txd_drv : !(mode_q == MODE_FAILSAFE && local_q);
   // Driver stays off until transmit was high over 10us
   assign bus = (hi_q > 250) ? o_txd_pin : 1'b1;
   assign o_rxd = (mode_q == MODE_NORMAL) ? bus : !flag_q;
   assign o_inh = (mode_q != MODE_SLEEP);
   // Mode changes on wake, mode request rise and mode request fall
   always @(posedge i_mclk) begin
      en_q <= i_en;
      // A new local wake needs the pin released over 6us first
      rel_q <= i_wake_pin ? 0 : ((rel_q > 150) ? rel_q : rel_q + 1);
      if (mode_q != MODE_NORMAL) begin
         hi_q <= 0;
      end else if (hi_q <= 250) begin
         hi_q <= o_txd_pin ? hi_q + 1 : 0;
      end
      if (mode_q == MODE_SLEEP && (i_wake_bus || (i_wake_pin && rel_q > 150))) begin
         mode_q <= MODE_FAILSAFE;
         flag_q <= 1'b1;
         local_q <= i_wake_pin;
      end else if (mode_q == MODE_FAILSAFE && i_en && !en_q) begin
         mode_q <= MODE_NORMAL;
         flag_q <= 1'b0;
         local_q <= 1'b0;
      end else if (mode_q == MODE_NORMAL && !i_en && en_q && o_txd_pin) begin
         mode_q <= MODE_SLEEP;
      end
   end
endmodule

// ---- bench/lnhc_top_chk.sv ----
// Port checker for the mode controller top.
// Assumes it is bound to every instance of the top module.
`timescale 1ns/100ps
module lnhc_top_chk
   import lnhc_pkg::*;
#(
   parameter int DOM_LIMIT_CYC = DOM_TIMEOUT_CYC
) (
   input wire logic i_mclk,
   input wire logic i_rstn,
   input wire logic i_go_normal,
   input wire logic i_go_sleep,
   input wire logic i_tx_valid,
   input wire logic i_tx_bit,
   input wire logic o_tx_ready,
   input wire logic o_bus_level,
   input wire logic [1:0] o_mode,
   input wire logic o_wake_pulse,
   input wire logic o_wake_local,
   input wire logic o_regulator_on,
   input wire logic o_mode_request,
   input wire logic o_txd_out,
   input wire logic o_txd_oe,
   input wire logic i_txd_in,
   input wire logic i_rxd,
   input wire logic i_regulator_inhibit
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rstn);
   // Counts arming cycles while mode request is high before normal shows
   logic [11:0] arm_cnt_q;
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         arm_cnt_q <= 12'h000;
      end else if (!o_mode_request) begin
         arm_cnt_q <= 12'h000;
      end else if (o_mode != MODE_NORMAL && arm_cnt_q != 12'hfff) begin
         arm_cnt_q <= arm_cnt_q + 12'h001;
      end
   end
   // -------------------------------------------
   // Assertions
   // -------------------------------------------
   arm_high_a: assert property ($rose(o_mode_request) |-> (o_txd_oe && o_txd_out) [*8])
      else $error("transmit not held high while arming");
   normal_late_a: assert property ($rose(o_mode == MODE_NORMAL) |-> arm_cnt_q >= 12'(ARM_CYC))
      else $error("normal mode before arming time");
   sleep_drop_a: assert property ($fell(o_mode_request) |-> !o_txd_oe && $past(o_txd_oe && o_txd_out))
      else $error("mode request fell without transmit high");
   sleep_setup_a: assert property ($fell(o_mode_request) |-> $past(o_txd_oe && o_txd_out, 20))
      else $error("transmit high too short before sleep");
   normal_req_a: assert property (o_mode == MODE_NORMAL |-> o_mode_request)
      else $error("normal mode without mode request");
   pulse_one_a: assert property (o_wake_pulse |=> !o_wake_pulse)
      else $error("wake pulse longer than one cycle");
   wake_src_a: assert property (o_wake_pulse |-> o_wake_local == !$past(i_txd_in, 6))
      else $error("wake source misread");
   wake_hold_a: assert property (!o_wake_pulse |-> $stable(o_wake_local))
      else $error("wake source changed without capture");
   bus_mirror_a: assert property (i_rxd [*6] |-> o_bus_level)
      else $error("bus level not recessive");
   cover property (o_wake_pulse && o_wake_local);
   cover property (o_wake_pulse && !o_wake_local);
   cover property ($fell(o_mode_request));
endmodule
bind lnhc_top lnhc_top_chk #(.DOM_LIMIT_CYC(DOM_LIMIT_CYC)) u_lnhc_top_chk (
   .i_mclk(i_mclk), .i_rstn(i_rstn), .i_go_normal(i_go_normal), .i_go_sleep(i_go_sleep),
   .i_tx_valid(i_tx_valid), .i_tx_bit(i_tx_bit), .o_tx_ready(o_tx_ready), .o_bus_level(o_bus_level),
   .o_mode(o_mode), .o_wake_pulse(o_wake_pulse), .o_wake_local(o_wake_local), .o_regulator_on(o_regulator_on),
   .o_mode_request(o_mode_request), .o_txd_out(o_txd_out), .o_txd_oe(o_txd_oe), .i_txd_in(i_txd_in),
   .i_rxd(i_rxd), .i_regulator_inhibit(i_regulator_inhibit));

// ---- bench/tb_lnhc_top.sv ----
// Self-checking bench for the transceiver mode controller.
// Assumes the transceiver model and the bound checker.
`timescale 1ns/100ps
module tb_lnhc_top;
   import lnhc_pkg::*;
   localparam int DL = 50;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic go_normal = 1'b0;
   logic go_sleep = 1'b0;
   logic tx_valid = 1'b0;
   logic tx_bit = 1'b1;
   logic wake_bus = 1'b0;
   logic wake_pin = 1'b0;
   logic tx_ready, bus_level, wake_pulse, wake_local, reg_on, mode_req, txd_out, txd_oe, txd_pin, rxd, regulator_inhibit_out;
   logic seen;
   logic [1:0] mode;
   logic [2:0] rows [3] = '{3'h5, 3'h2, 3'h5}; // Wake pin, wake bus, expected local flag
   int n_fail = 0;
   int samples_checked = 0;
   int cyc = 0;
   int t;
   int acc;
   lnhc_top #(.DOM_LIMIT_CYC(DL)) u_lnhc_top (
      .i_mclk(mclk), .i_rstn(rstn), .i_go_normal(go_normal), .i_go_sleep(go_sleep),
      .i_tx_valid(tx_valid), .i_tx_bit(tx_bit), .o_tx_ready(tx_ready), .o_bus_level(bus_level),
      .o_mode(mode), .o_wake_pulse(wake_pulse), .o_wake_local(wake_local), .o_regulator_on(reg_on),
      .o_mode_request(mode_req), .o_txd_out(txd_out), .o_txd_oe(txd_oe), .i_txd_in(txd_pin),
      .i_rxd(rxd), .i_regulator_inhibit(regulator_inhibit_out));
   lnhc_xcvr_model u_lnhc_xcvr_model (
      .i_mclk(mclk), .i_en(mode_req), .i_txd_drv(txd_out), .i_txd_oe(txd_oe), .i_wake_bus(wake_bus),
      .i_wake_pin(wake_pin), .o_txd_pin(txd_pin), .o_rxd(rxd), .o_inh(regulator_inhibit_out));
   // -------------------------------------------
   // Clock, timeout and shared tasks
   // -------------------------------------------
   initial begin
      forever #20 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         $display("unexpected at %0t: timeout", $time);
         report_and_stop();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic chk(input logic ok, input string m);
      samples_checked++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask
   task automatic report_and_stop();
      if (n_fail == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic to_mode(input logic [1:0] m);
      t = 0;
      while (mode !== m && t < 3000) begin
         tick(1);
         t++;
      end
   endtask
   task automatic wake(input logic pin, input logic bus);
      wake_pin = pin;
      wake_bus = bus;
      tick(1);
      wake_pin = 1'b0;
      wake_bus = 1'b0;
      t = 0;
      while (wake_pulse !== 1'b1 && t < 400) begin
         tick(1);
         t++;
      end
      chk(t < 400, "no wake pulse");
   endtask
   task automatic enter(input logic [1:0] m);
      go_normal = (m == MODE_NORMAL);
      go_sleep = (m == MODE_SLEEP);
      tick(1);
      go_normal = 1'b0;
      go_sleep = 1'b0;
      to_mode(m);
      // Sleep shows at once, the mode request falls after the transmit setup
      if (m == MODE_SLEEP) begin
         tick(int'(SLEEP_SETUP_CYC) + 2);
      end
   endtask
   // -------------------------------------------
   // Sequence
   // -------------------------------------------
   initial begin
      tick(16);
      rstn = 1'b1;
      tick(1);
      for (int r = 0; r < 3; r++) begin
         wake(rows[r][2], rows[r][1]);
         chk(wake_local === rows[r][0], "wrong wake source");
         tick(8);
         chk(reg_on === 1'b1, "regulator off after wake");
         enter(MODE_NORMAL);
         chk(mode === MODE_NORMAL && t >= 250, "arming time wrong");
         chk(bus_level === 1'b1, "wake flag not cleared");
         tx_valid = 1'b1;
         tx_bit = 1'b0;
         tick(1);
         tx_valid = 1'b0;
         to_mode(MODE_NORMAL);
         for (int k = 0; k < 10 && txd_out !== 1'b0; k++) tick(1);
         t = 0;
         seen = 1'b0;
         while (txd_out === 1'b0 && t < 2000) begin
            seen |= (bus_level === 1'b0);
            tick(1);
            t++;
         end
         chk(t >= DL - 1 && t <= DL + 1, "dominant guard length");
         chk(seen, "bus not dominant");
         enter(MODE_SLEEP);
         chk(mode === MODE_SLEEP && mode_req === 1'b0, "sleep not entered");
         tick(8);
         chk(reg_on === 1'b0, "regulator on in sleep");
      end
      // Mode request outside fail-safe is ignored
      go_normal = 1'b1;
      tick(1);
      go_normal = 1'b0;
      tick(4);
      chk(mode_req === 1'b0 && mode === MODE_SLEEP, "request taken in sleep");
      // Buffer fills to two while the stream stalls, then drains in order
      wake(1'b1, 1'b0);
      tx_valid = 1'b1;
      acc = 0;
      for (int k = 0; k < 4; k++) begin
         tx_bit = (k == 0);
         acc += int'(tx_ready === 1'b1);
         tick(1);
      end
      tx_valid = 1'b0;
      chk(acc == 2 && tx_ready === 1'b0, "buffer depth");
      enter(MODE_NORMAL);
      t = 0;
      while (txd_out !== 1'b0 && t < 3000) begin
         tick(1);
         t++;
      end
      chk(t > 1000 && t < 3000 && tx_ready === 1'b1, "bit order or time");
      enter(MODE_SLEEP);
      // Reset in mid-run after a local wake
      rstn = 1'b0;
      tick(1);
      chk(mode_req === 1'b0 && txd_oe === 1'b0 && txd_out === 1'b1 && mode === MODE_SLEEP, "reset pins");
      chk(bus_level === 1'b1 && wake_local === 1'b0 && reg_on === 1'b0 && tx_ready === 1'b1, "reset user");
      rstn = 1'b1;
      tick(2);
      chk(mode === MODE_SLEEP && txd_oe === 1'b0 && mode_req === 1'b0, "state after reset");
      report_and_stop();
   end
endmodule
